//--- rtl/hio_pkg.sv
// package for the homing and i/o command handler
// assumes an apb master with 32-bit data and aligned word registers
// ****************************************************************
// Notes on behaviour
// - opcode 13, types start/stop/status, motor zero
// - status query answers zero when no search runs
// - start or stop answers status 100
// - opcode 14 sets selected line to level
// - bank 2 port 0 is general output
// - port 0 bank 0 sets pull-up bits
// - all pull-ups enabled after reset
// - opcode 15 reads port of bank 0-2
// - digital reads 0/1, analog 0..4095
// - standalone copies result into accumulator
// - bank 0 ports 0-2 give digital inputs
// - port 255 bank 0 packs all inputs
// - bank 1 gives analog, voltage, temperature
// - output level can be read back
// - bank 2 port 0 returns output level
// ****************************************************************
package hio_pkg;
    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] hio_off_control = 8'h00; // mode and addresses
    localparam logic [7:0] hio_off_cmd_header = 8'h04; // address, opcode, type, bank
    localparam logic [7:0] hio_off_cmd_value = 8'h08; // 32-bit value
    localparam logic [7:0] hio_off_cmd_checksum = 8'h0C; // checksum, write executes
    localparam logic [7:0] hio_off_reply_header = 8'h10; // host, target, status, opcode
    localparam logic [7:0] hio_off_reply_value = 8'h14; // reply value
    localparam logic [7:0] hio_off_reply_checksum = 8'h18; // checksum and valid flag
    localparam logic [7:0] hio_off_accumulator = 8'h1C; // accumulator
    localparam logic [7:0] hio_off_io_state = 8'h20; // live i/o state
    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int hio_pos_standalone = 0; // control: standalone mode bit
    localparam int hio_pos_reply_valid = 8; // reply checksum: valid flag
    localparam logic [7:0] hio_rst_module_address = 8'h01; // own address after reset
    localparam logic [7:0] hio_rst_host_address = 8'h02; // host address after reset
    localparam logic [1:0] hio_rst_pullup = 2'h3; // all pull-ups on
    // ************************************************************
    // opcodes, types, banks, ports, status codes
    // ************************************************************
    localparam logic [7:0] hio_op_homing = 8'h0D; // homing_search_command
    localparam logic [7:0] hio_op_set_output = 8'h0E; // set_output_command
    localparam logic [7:0] hio_op_get_input = 8'h0F; // get_input_command
    localparam logic [7:0] hio_type_start = 8'h00;
    localparam logic [7:0] hio_type_stop = 8'h01;
    localparam logic [7:0] hio_type_status = 8'h02;
    localparam logic [7:0] hio_bank_digital = 8'h00;
    localparam logic [7:0] hio_bank_analog = 8'h01;
    localparam logic [7:0] hio_bank_output = 8'h02;
    localparam logic [7:0] hio_port_all = 8'hFF;
    localparam logic [7:0] hio_port_voltage = 8'h08;
    localparam logic [7:0] hio_port_temperature = 8'h09;
    localparam logic [7:0] hio_st_ok = 8'h64; // 100
    localparam logic [7:0] hio_st_bad_checksum = 8'h01;
    localparam logic [7:0] hio_st_bad_command = 8'h02;
    localparam logic [7:0] hio_st_bad_type = 8'h03;
    localparam logic [7:0] hio_st_bad_value = 8'h04;
    // ************************************************************
    // frame carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0] target;
        logic [7:0] opcode;
        logic [7:0] ctype;
        logic [7:0] bank;
        logic [31:0] value;
    } hio_cmd_t;
    typedef struct packed {
        logic [7:0] host;
        logic [7:0] target;
        logic [7:0] status;
        logic [7:0] opcode;
        logic [31:0] value;
    } hio_reply_t;
endpackage

//--- rtl/hio_top.sv
// homing and i/o command handler with an apb register port
// assumes pclk at 200 MHz, inputs synchronous to pclk, analog values already converted
`timescale 1ns/1ps
module hio_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic first_general_input,
    input wire logic second_general_input,
    input wire logic third_general_input,
    input wire logic [11:0] first_input_analog,
    input wire logic [15:0] supply_tenths_volt,
    input wire logic signed [15:0] temperature_celsius,
    input wire logic homing_active,
    output logic homing_start,
    output logic homing_stop,
    output logic general_output_zero,
    output logic [1:0] pullup_enable
);
    import hio_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    logic standalone; // 1: results go to the accumulator
    logic next_standalone;
    logic [7:0] module_address; // own frame address
    logic [7:0] next_module_address;
    logic [7:0] host_address; // address placed in replies
    logic [7:0] next_host_address;
    hio_cmd_t cmd; // command frame held for execution
    hio_cmd_t next_cmd;
    hio_reply_t reply; // last reply frame
    hio_reply_t next_reply;
    logic [7:0] reply_checksum; // checksum of last reply
    logic [7:0] next_reply_checksum;
    logic reply_valid; // sticky, cleared by reading the reply checksum
    logic next_reply_valid;
    logic [31:0] accumulator; // standalone result store
    logic [31:0] next_accumulator;
    logic next_homing_start;
    logic next_homing_stop;
    logic next_general_output_zero;
    logic [1:0] next_pullup_enable;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // ************************************************************
    // bus decode helpers
    // ************************************************************
    logic setup_phase; // first cycle of a transfer
    logic access_done; // edge at which the transfer completes
    logic mapped; // address hits a register
    logic [7:0] cmd_sum; // additive checksum of first eight bytes
    logic [7:0] reply_sum; // additive checksum of reply bytes
    logic [2:0] input_bits; // packed digital inputs
    hio_reply_t exec_reply; // reply computed for the held command
    logic exec_to_accumulator; // result also goes to the accumulator
    logic exec_forced_accumulator; // all-inputs read always fills it

    // transfer phases and address map
    always_comb begin
        setup_phase = psel && !penable;
        access_done = psel && penable && pready;
        // registers sit on aligned words from control up to io state
        // unmapped accesses answer with the error flag
        if (paddr[1:0] != 2'h0) begin
            // a byte offset inside a word is refused
            mapped = 1'b0;
        end else if (paddr > hio_off_io_state) begin
            // past the last register
            mapped = 1'b0;
        end else begin
            // every aligned word in the map is a register
            mapped = 1'b1;
        end
    end

    // ************************************************************
    // frame checksums
    // ************************************************************
    // additive 8-bit sums, carries dropped on purpose
    always_comb begin
        input_bits = {third_general_input, second_general_input, first_general_input};
        cmd_sum = 8'(cmd.target + cmd.opcode + cmd.ctype + cmd.bank);
        cmd_sum = 8'(cmd_sum + cmd.value[31:24] + cmd.value[23:16]);
        cmd_sum = 8'(cmd_sum + cmd.value[15:8] + cmd.value[7:0]);
        reply_sum = 8'(exec_reply.host + exec_reply.target + exec_reply.status);
        reply_sum = 8'(reply_sum + exec_reply.opcode + exec_reply.value[31:24]);
        reply_sum = 8'(reply_sum + exec_reply.value[23:16] + exec_reply.value[15:8]);
        reply_sum = 8'(reply_sum + exec_reply.value[7:0]);
    end

    // ************************************************************
    // command interpreter
    // ************************************************************
    // decodes the held frame against the checksum being written
    always_comb begin
        exec_reply.host = host_address;
        exec_reply.target = module_address;
        exec_reply.status = hio_st_ok;
        exec_reply.opcode = cmd.opcode;
        exec_reply.value = 32'h0;
        exec_to_accumulator = 1'b0;
        exec_forced_accumulator = 1'b0;
        if (pwdata[7:0] != cmd_sum) begin
            // corrupted frame: nothing executes
            exec_reply.status = hio_st_bad_checksum;
        end else begin
            case (cmd.opcode)
                hio_op_homing: begin
                    if (cmd.bank != 8'h00) begin
                        exec_reply.status = hio_st_bad_value;
                    end else if (cmd.ctype == hio_type_status) begin
                        exec_reply.value = {31'h0, homing_active};
                    end else if (cmd.ctype != hio_type_start && cmd.ctype != hio_type_stop) begin
                        exec_reply.status = hio_st_bad_type;
                    end
                end
                hio_op_set_output: begin
                    if (cmd.bank == hio_bank_output && cmd.ctype == 8'h00) begin
                        if (cmd.value > 32'h0000_0001) begin
                            exec_reply.status = hio_st_bad_value;
                        end
                    end else if (cmd.bank == hio_bank_digital && cmd.ctype == 8'h00) begin
                        if (cmd.value > 32'h0000_0003) begin
                            exec_reply.status = hio_st_bad_value;
                        end
                    end else begin
                        exec_reply.status = hio_st_bad_type;
                    end
                end
                hio_op_get_input: begin
                    exec_to_accumulator = standalone;
                    if (cmd.bank == hio_bank_digital && cmd.ctype == hio_port_all) begin
                        exec_reply.value = {29'h0, input_bits};
                        exec_forced_accumulator = 1'b1;
                    end else if (cmd.bank == hio_bank_digital && cmd.ctype < 8'h03) begin
                        exec_reply.value = {31'h0, input_bits[cmd.ctype[1:0]]};
                    end else if (cmd.bank == hio_bank_analog && cmd.ctype == 8'h00) begin
                        exec_reply.value = {20'h0, first_input_analog};
                    end else if (cmd.bank == hio_bank_analog && cmd.ctype == hio_port_voltage) begin
                        exec_reply.value = {16'h0000, supply_tenths_volt};
                    end else if (cmd.bank == hio_bank_analog && cmd.ctype == hio_port_temperature) begin
                        exec_reply.value = 32'(temperature_celsius);
                    end else if (cmd.bank == hio_bank_output && cmd.ctype == 8'h00) begin
                        exec_reply.value = {31'h0, general_output_zero};
                    end else if (cmd.bank > hio_bank_output) begin
                        exec_reply.status = hio_st_bad_value;
                        exec_to_accumulator = 1'b0;
                    end else begin
                        exec_reply.status = hio_st_bad_type;
                        exec_to_accumulator = 1'b0;
                    end
                end
                default: begin
                    exec_reply.status = hio_st_bad_command;
                end
            endcase
        end
    end

    // ************************************************************
    // register and action next state
    // ************************************************************
    // apb writes, command execution and read data capture
    always_comb begin
        logic execute;
        logic ok;
        execute = access_done && pwrite && paddr == hio_off_cmd_checksum && cmd.target == module_address;
        ok = exec_reply.status == hio_st_ok;
        next_standalone = standalone;
        next_module_address = module_address;
        next_host_address = host_address;
        next_cmd = cmd;
        next_reply = reply;
        next_reply_checksum = reply_checksum;
        next_reply_valid = reply_valid;
        next_accumulator = accumulator;
        next_homing_start = 1'b0;
        next_homing_stop = 1'b0;
        next_general_output_zero = general_output_zero;
        next_pullup_enable = pullup_enable;
        next_pready = setup_phase;
        next_pslverr = setup_phase && !mapped;
        next_prdata = 32'h0;
        // software writes
        if (access_done && pwrite) begin
            if (paddr == hio_off_control) begin
                next_standalone = pwdata[hio_pos_standalone];
                next_module_address = pwdata[15:8];
                next_host_address = pwdata[23:16];
            end else if (paddr == hio_off_cmd_header) begin
                next_cmd.target = pwdata[31:24];
                next_cmd.opcode = pwdata[23:16];
                next_cmd.ctype = pwdata[15:8];
                next_cmd.bank = pwdata[7:0];
            end else if (paddr == hio_off_cmd_value) begin
                next_cmd.value = pwdata;
            end else if (paddr == hio_off_accumulator) begin
                next_accumulator = pwdata;
            end
        end
        // reading the reply checksum consumes the reply
        if (access_done && !pwrite && paddr == hio_off_reply_checksum) begin
            next_reply_valid = 1'b0;
        end
        // frame for another address is ignored without reply
        if (execute) begin
            next_reply = exec_reply;
            next_reply_checksum = reply_sum;
            next_reply_valid = 1'b1; // set wins over a clear
            if (ok && (exec_to_accumulator || exec_forced_accumulator)) begin
                next_accumulator = exec_reply.value;
            end
            if (ok && cmd.opcode == hio_op_homing) begin
                next_homing_start = cmd.ctype == hio_type_start;
                next_homing_stop = cmd.ctype == hio_type_stop;
            end
            if (ok && cmd.opcode == hio_op_set_output && cmd.bank == hio_bank_output) begin
                next_general_output_zero = cmd.value[0];
            end
            if (ok && cmd.opcode == hio_op_set_output && cmd.bank == hio_bank_digital) begin
                next_pullup_enable = cmd.value[1:0];
            end
        end
        // read data is captured in the setup cycle
        if (setup_phase && !pwrite) begin
            if (paddr == hio_off_control) begin
                next_prdata = {8'h00, host_address, module_address, 7'h00, standalone};
            end else if (paddr == hio_off_cmd_header) begin
                next_prdata = {cmd.target, cmd.opcode, cmd.ctype, cmd.bank};
            end else if (paddr == hio_off_cmd_value) begin
                next_prdata = cmd.value;
            end else if (paddr == hio_off_reply_header) begin
                next_prdata = {reply.host, reply.target, reply.status, reply.opcode};
            end else if (paddr == hio_off_reply_value) begin
                next_prdata = reply.value;
            end else if (paddr == hio_off_reply_checksum) begin
                next_prdata = {23'h0, reply_valid, reply_checksum};
            end else if (paddr == hio_off_accumulator) begin
                next_prdata = accumulator;
            end else if (paddr == hio_off_io_state) begin
                next_prdata = {24'h0, homing_active, 1'b0, input_bits,
                    pullup_enable, general_output_zero};
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // only stores next values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standalone <= 1'b0;
            module_address <= hio_rst_module_address;
            host_address <= hio_rst_host_address;
            cmd <= '0;
            reply <= '0;
            reply_checksum <= 8'h00;
            reply_valid <= 1'b0;
            accumulator <= 32'h0;
            homing_start <= 1'b0;
            homing_stop <= 1'b0;
            general_output_zero <= 1'b0;
            pullup_enable <= hio_rst_pullup;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            standalone <= next_standalone;
            module_address <= next_module_address;
            host_address <= next_host_address;
            cmd <= next_cmd;
            reply <= next_reply;
            reply_checksum <= next_reply_checksum;
            reply_valid <= next_reply_valid;
            accumulator <= next_accumulator;
            homing_start <= next_homing_start;
            homing_stop <= next_homing_stop;
            general_output_zero <= next_general_output_zero;
            pullup_enable <= next_pullup_enable;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end
endmodule

//--- bench/hio_monitor.sv
// checker for the homing and i/o command handler
// assumes it is bound to hio_top and sees only its ports
`timescale 1ns/1ps
module hio_monitor
    import hio_pkg::*;
(
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic pready,
    input logic pslverr,
    input logic homing_start,
    input logic homing_stop,
    input logic general_output_zero,
    input logic [1:0] pullup_enable
);
    // ****************************************
    // shadow of the held command
    // ****************************************
    logic [31:0] hdr; // header as written
    logic [31:0] val; // value as written
    logic [7:0] maddr; // own address
    logic [7:0] sum;
    logic wr;
    logic exec;
    assign wr = psel && penable && pready && pwrite;
    assign sum = hdr[31:24] + hdr[23:16] + hdr[15:8] + hdr[7:0] + val[31:24] + val[23:16] + val[15:8] + val[7:0];
    assign exec = wr && paddr == hio_off_cmd_checksum && hdr[31:24] == maddr && pwdata[7:0] == sum;
    // tracks completed writes only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hdr <= 32'h0;
            val <= 32'h0;
            maddr <= hio_rst_module_address;
        end else begin
            if (wr && paddr == hio_off_cmd_header) hdr <= pwdata;
            if (wr && paddr == hio_off_cmd_value) val <= pwdata;
            if (wr && paddr == hio_off_control) maddr <= pwdata[15:8];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence homing_cmd_s(logic [7:0] t);
        exec && hdr[23:16] == hio_op_homing && hdr[15:8] == t && hdr[7:0] == 8'h00;
    endsequence
    sequence set_out_s(logic [7:0] b, logic [31:0] lim);
        exec && hdr[23:16] == hio_op_set_output && hdr[15:8] == 8'h00 && hdr[7:0] == b && val <= lim;
    endsequence
    start_pulse_a: assert property (homing_cmd_s(hio_type_start) |=> homing_start ##1 !homing_start)
        else $error("homing start pulse missing");
    stop_pulse_a: assert property (homing_cmd_s(hio_type_stop) |=> homing_stop)
        else $error("homing stop pulse missing");
    no_stray_pulse_a: assert property (!(exec && hdr[23:16] == hio_op_homing && hdr[15:8] < 8'h02
        && hdr[7:0] == 8'h00) |=> !homing_start && !homing_stop)
        else $error("homing pulse without command");
    out_set_a: assert property (set_out_s(hio_bank_output, 32'h1) |=> general_output_zero == val[0])
        else $error("output level not taken");
    pullup_set_a: assert property (set_out_s(hio_bank_digital, 32'h3) |=> pullup_enable == val[1:0])
        else $error("pull-up bits not taken");
    out_hold_a: assert property (!exec |=> $stable(general_output_zero) && $stable(pullup_enable))
        else $error("outputs changed without command");
    pullup_reset_a: assert property ($rose(presetn) |-> pullup_enable == hio_rst_pullup)
        else $error("pull-ups not all on after reset");
    apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("bus answer not one cycle");
    unmapped_err_a: assert property (pready |-> pslverr == (paddr > hio_off_io_state || paddr[1:0] != 2'h0))
        else $error("error flag wrong");
endmodule
bind hio_top hio_monitor hio_mon_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .homing_start, .homing_stop, .general_output_zero, .pullup_enable);

//--- bench/hio_homing_model.sv
// homing engine model answering the start and stop pulses
// assumes one-cycle pulses from hio_top on pclk
`timescale 1ns/1ps
module hio_homing_model #(
    parameter int RUN_LEN = 300
) (
    input logic pclk,
    input logic presetn,
    input logic homing_start,
    input logic homing_stop,
    output logic homing_active
);
    int left; // cycles until home is found
    // search runs until stopped or until it ends by itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left <= 0;
        end else if (homing_stop) begin
            left <= 0;
        end else if (homing_start) begin
            left <= RUN_LEN;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
    assign homing_active = (left > 0);
endmodule

//--- bench/tb_top.sv
// testbench for the homing and i/o command handler
// assumes hio_top, the homing model and the bound checker
`timescale 1ns/1ps
module tb_top;
    import hio_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, hs, hp, gout, hact;
    logic [1:0] pup;
    logic [2:0] gin = 3'h0;
    logic [11:0] ana = 12'h000;
    logic [15:0] volt = 16'h0000;
    logic signed [15:0] temp = 16'sh0000;
    logic [64:0] notes[$]; // pending reads: error flag, mask, data
    logic [64:0] nt;
    int errors = 0, checks = 0, cycles = 0, seed = 37899;
    hio_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .first_general_input(gin[0]), .second_general_input(gin[1]), .third_general_input(gin[2]),
        .first_input_analog(ana), .supply_tenths_volt(volt), .temperature_celsius(temp),
        .homing_active(hact), .homing_start(hs), .homing_stop(hp), .general_output_zero(gout),
        .pullup_enable(pup));
    hio_homing_model #(.RUN_LEN(300)) hm_u (.pclk, .presetn, .homing_start(hs),
        .homing_stop(hp), .homing_active(hact));
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    // ****************************************
    // checking and closing
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // takes the oldest note when a read completes
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
        if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
            nt = notes.pop_front();
            check("read data", prdata & nt[63:32], nt[31:0]);
            check("slave error", {31'h0, pslverr}, {31'h0, nt[64]});
        end
    end
    // ****************************************
    // bus and command tasks
    // ****************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, m, input logic err = 1'b0);
        notes.push_back({err, m, exp});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic cmd(input logic [7:0] tg, op, ty, bk, input logic [31:0] v, input logic [7:0] bad);
        logic [7:0] s;
        s = tg + op + ty + bk + v[31:24] + v[23:16] + v[15:8] + v[7:0] + bad;
        apb(1'b1, hio_off_cmd_header, {tg, op, ty, bk});
        apb(1'b1, hio_off_cmd_value, v);
        apb(1'b1, hio_off_cmd_checksum, {24'h0, s});
    endtask
    task automatic reply(input logic [7:0] st, op, input logic [31:0] v, m);
        logic [7:0] s;
        s = hio_rst_host_address + hio_rst_module_address + st + op + v[31:24] + v[23:16] + v[15:8] + v[7:0];
        rd(hio_off_reply_header, {hio_rst_host_address, hio_rst_module_address, st, op}, '1);
        rd(hio_off_reply_value, v, m);
        if (m == '1) rd(hio_off_reply_checksum, {23'h0, 1'b1, s}, 32'h1FF);
    endtask
    task automatic exe(input logic [7:0] op, ty, bk, bad, st, input logic [31:0] v, rv, m);
        cmd(8'h01, op, ty, bk, v, bad);
        reply(st, op, rv, m);
    endtask
    task automatic get_input_command(input logic [7:0] p, b, input logic [31:0] exp);
        exe(hio_op_get_input, p, b, 8'h00, hio_st_ok, '0, exp, '1);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(hio_off_control, 32'h00020100, '1);
        rd(hio_off_io_state, 32'h6, 32'h7);
        exe(hio_op_homing, hio_type_start, 8'h00, 8'h00, hio_st_ok, '0, '0, '0);
        exe(hio_op_homing, hio_type_status, 8'h00, 8'h00, hio_st_ok, '0, 32'h1, '1);
        exe(hio_op_homing, hio_type_stop, 8'h00, 8'h00, hio_st_ok, '0, '0, '0);
        exe(hio_op_homing, hio_type_start, 8'h00, 8'h01, hio_st_bad_checksum, '0, '0, '0);
        exe(hio_op_homing, hio_type_status, 8'h00, 8'h00, hio_st_ok, '0, '0, '1);
        for (int v = 1; v >= 0; v--) begin
            exe(hio_op_set_output, 8'h00, hio_bank_output, 8'h00, hio_st_ok, v, '0, '0);
            check("output line", {31'h0, gout}, v);
            get_input_command(8'h00, hio_bank_output, v);
        end
        for (int v = 0; v < 4; v++) begin
            exe(hio_op_set_output, 8'h00, hio_bank_digital, 8'h00, hio_st_ok, v, '0, '0);
            check("pull-ups", {30'h0, pup}, v);
        end
        exe(hio_op_set_output, 8'h00, hio_bank_digital, 8'h00, hio_st_bad_value, 32'h4, '0, '0);
        check("pull-ups kept", {30'h0, pup}, 32'h3);
        gin <= 3'($random(seed));
        ana <= 12'($random(seed));
        volt <= 16'($random(seed));
        temp <= 16'($random(seed));
        @(posedge pclk);
        for (int p = 0; p < 3; p++) get_input_command(p, hio_bank_digital, gin[p]);
        get_input_command(hio_port_all, hio_bank_digital, {29'h0, gin});
        rd(hio_off_accumulator, {29'h0, gin}, '1);
        apb(1'b1, hio_off_accumulator, 32'h5A5A5A5A);
        get_input_command(8'h00, hio_bank_analog, {20'h0, ana});
        get_input_command(hio_port_voltage, hio_bank_analog, {16'h0, volt});
        get_input_command(hio_port_temperature, hio_bank_analog, {{16{temp[15]}}, temp});
        rd(hio_off_accumulator, 32'h5A5A5A5A, '1);
        apb(1'b1, hio_off_control, 32'h00020101);
        get_input_command(8'h01, hio_bank_digital, gin[1]);
        rd(hio_off_accumulator, {31'h0, gin[1]}, '1);
        exe(8'h13, 8'h00, 8'h00, 8'h00, hio_st_bad_command, '0, '0, '0);
        exe(hio_op_get_input, 8'h00, 8'h03, 8'h00, hio_st_bad_value, '0, '0, '0);
        rd(hio_off_reply_checksum, 32'h100, 32'h100);
        cmd(8'h05, hio_op_get_input, 8'h00, 8'h00, 32'h0, 8'h00);
        rd(hio_off_reply_checksum, 32'h0, 32'h100);
        rd(8'h24, 32'h0, '1, 1'b1);
        repeat (3) @(posedge pclk);
        report_and_stop();
    end
endmodule
